// ==== logic/pls_consts.svh ====
`ifndef PLS_CONSTS_SVH
`define PLS_CONSTS_SVH

// Register location and field layout
`define PLS_CFG_ADDR       5'h14
`define PLS_SEL1_HI        15
`define PLS_SEL1_LO        12
`define PLS_SEL2_HI        11
`define PLS_SEL2_LO        8
`define PLS_FREQ_HI        3
`define PLS_FREQ_LO        2
`define PLS_STRETCH_BIT    1
`define PLS_CFG_RESET      16'h0402
`define PLS_CFG_MASK       16'hFF0E

// Timing
`define PLS_CLK_PERIOD_NS  4
`define PLS_TICK_NS        1000000
`define PLS_HOLD0_MS       30
`define PLS_HOLD1_MS       60

`endif

// ==== logic/pls_pkg.sv ====
package pls_pkg;

	typedef logic [3:0] pls_sel_t;
	typedef logic [7:0] pls_ms_t;
	typedef logic [15:0] pls_word_t;

	typedef enum logic [3:0] {
		PLS_SPEED      = 4'h0,
		PLS_TX         = 4'h1,
		PLS_RX         = 4'h2,
		PLS_COL        = 4'h3,
		PLS_LINK       = 4'h4,
		PLS_DUPLEX     = 4'h5,
		PLS_UNUSED_A   = 4'h6,
		PLS_ACT        = 4'h7,
		PLS_ON         = 4'h8,
		PLS_OFF        = 4'h9,
		PLS_FAST       = 4'hA,
		PLS_SLOW       = 4'hB,
		PLS_LINK_RX    = 4'hC,
		PLS_LINK_ACT   = 4'hD,
		PLS_DUP_COL    = 4'hE,
		PLS_UNUSED_B   = 4'hF
	} pls_code_t;

endpackage

// ==== logic/pls_if.sv ====
`timescale 1ns/1ns
interface pls_if;
	logic             tick;
	logic             blink_fast;
	logic             blink_slow;
	logic             stretch_en;
	pls_pkg::pls_ms_t hold_ms;
	logic             speed;
	logic             tx;
	logic             rx;
	logic             col;
	logic             link;
	logic             duplex;

	modport src (
		output tick, blink_fast, blink_slow, stretch_en, hold_ms,
		output speed, tx, rx, col, link, duplex
	);
	modport lane (
		input tick, blink_fast, blink_slow, stretch_en, hold_ms,
		input speed, tx, rx, col, link, duplex
	);
endinterface

// ==== logic/pls_lane.sv ====
`timescale 1ns/1ns
module pls_lane (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// Display select
	input  wire pls_pkg::pls_sel_t sel,
	// Shared timing and status
	pls_if.lane                    bus,
	// Indicator
	output logic                   lit
);

	pls_pkg::pls_ms_t cnt_reg;
	pls_pkg::pls_ms_t cnt_next;
	logic             lit_reg;
	logic             lit_next;
	logic             event_now;
	logic             combined;
	logic             held;
	logic             shown;

	always_comb begin
		event_now = 1'b0;
		combined  = 1'b0;
		case (sel)
			pls_pkg::PLS_TX:       event_now = bus.tx;
			pls_pkg::PLS_RX:       event_now = bus.rx;
			pls_pkg::PLS_COL:      event_now = bus.col;
			pls_pkg::PLS_ACT:      event_now = bus.rx | bus.tx;
			pls_pkg::PLS_LINK_RX: begin
				event_now = bus.rx;
				combined  = 1'b1;
			end
			pls_pkg::PLS_LINK_ACT: begin
				event_now = bus.rx | bus.tx;
				combined  = 1'b1;
			end
			pls_pkg::PLS_DUP_COL: begin
				event_now = bus.col;
				combined  = 1'b1;
			end
			default: begin
				event_now = 1'b0;
				combined  = 1'b0;
			end
		endcase
	end

	// Retriggerable hold counter in millisecond ticks
	always_comb begin
		cnt_next = cnt_reg;
		if (event_now) begin
			cnt_next = bus.hold_ms;
		end else if (bus.tick && cnt_reg != '0) begin
			cnt_next = cnt_reg - pls_pkg::pls_ms_t'(1);
		end
	end

	assign held  = event_now | (cnt_reg != '0);
	assign shown = (combined | bus.stretch_en) ? held : event_now;

	always_comb begin
		case (sel)
			pls_pkg::PLS_SPEED:    lit_next = bus.speed;
			pls_pkg::PLS_TX,
			pls_pkg::PLS_RX,
			pls_pkg::PLS_COL,
			pls_pkg::PLS_ACT:      lit_next = shown;
			pls_pkg::PLS_LINK:     lit_next = bus.link;
			pls_pkg::PLS_DUPLEX:   lit_next = bus.duplex;
			pls_pkg::PLS_ON:       lit_next = 1'b1;
			pls_pkg::PLS_OFF:      lit_next = 1'b0;
			pls_pkg::PLS_FAST:     lit_next = bus.blink_fast;
			pls_pkg::PLS_SLOW:     lit_next = bus.blink_slow;
			pls_pkg::PLS_LINK_RX,
			pls_pkg::PLS_LINK_ACT: lit_next = bus.link ^ (shown & bus.blink_fast);
			pls_pkg::PLS_DUP_COL:  lit_next = bus.duplex ^ (shown & bus.blink_fast);
			default:               lit_next = 1'b0;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= '0;
			lit_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			lit_reg <= lit_next;
		end
	end

	assign lit = lit_reg;

endmodule

// ==== logic/pls_top.sv ====
`timescale 1ns/1ns
`include "pls_consts.svh"
//
// Contract
// - First indicator select at bits 15:12, read/write, resets to speed display.
// - Second indicator select at bits 11:8, read/write, resets to link display.
// - Codes 1, 2, 3 show stretched transmit, receive, collision events.
// - Code 4 follows link, code 5 follows duplex, no stretching.
// - Code 7 shows stretched receive-or-transmit activity.
// - Codes 8 and 9 force the indicator on and off.
// - Codes A and B blink the indicator fast and slow.
// - Codes 6 and F unused; indicator stays dark for them.
// - Code C: on while link up, blinks on stretched receive.
// - Code D: on while link up, blinks on stretched activity.
// - In combined link modes link drives; activity makes it change state.
// - Code E: on while full duplex, blinks on stretched collision.
// - Combined modes stretch always, regardless of the stretch enable bit.
// - Bit 1 enables stretching of plain event displays; resets to one.
// - Bits 3:2 pick hold time; code 00 gives 30 ms, the reset.
module pls_top #(
	parameter int TICK_CYCLES   = `PLS_TICK_NS / `PLS_CLK_PERIOD_NS,
	parameter int HOLD2_MS      = 90,
	parameter int HOLD3_MS      = 120,
	parameter int FAST_HALF_MS  = 50,
	parameter int SLOW_HALF_MS  = 250
) (
	// Clock and reset
	input  wire logic                REF_CLK,
	input  wire logic                RST,
	// Line status from the transceiver core
	input  wire logic                SPEED_100,
	input  wire logic                TX_ACTIVE,
	input  wire logic                RX_ACTIVE,
	input  wire logic                COLLISION,
	input  wire logic                LINK_UP,
	input  wire logic                FULL_DUPLEX,
	// Management register port
	input  wire logic [4:0]          REG_ADDR,
	input  wire logic                REG_WR_EN,
	input  wire logic                REG_RD_EN,
	input  wire pls_pkg::pls_word_t  REG_WDATA,
	output logic      [15:0]         REG_RDATA,
	output logic                     REG_RD_VALID,
	// Indicator drives
	output logic                     FIRST_INDICATOR,
	output logic                     SECOND_INDICATOR
);

	function automatic logic cfg_hit(input logic [4:0] addr);
		cfg_hit = (addr == `PLS_CFG_ADDR);
	endfunction

	pls_if bus ();

	// Configuration register and read-back
	pls_pkg::pls_word_t cfg_reg;
	pls_pkg::pls_word_t cfg_next;
	pls_pkg::pls_word_t rdata_reg;
	pls_pkg::pls_word_t rdata_next;
	logic               rvalid_reg;
	logic               rvalid_next;

	always_comb begin
		cfg_next    = cfg_reg;
		rdata_next  = rdata_reg;
		rvalid_next = 1'b0;
		if (REG_WR_EN && cfg_hit(REG_ADDR)) begin
			cfg_next = REG_WDATA & `PLS_CFG_MASK;
		end
		if (REG_RD_EN) begin
			rvalid_next = 1'b1;
			rdata_next  = cfg_hit(REG_ADDR) ? cfg_reg : 16'h0000;
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			cfg_reg    <= `PLS_CFG_RESET;
			rdata_reg  <= 16'h0000;
			rvalid_reg <= 1'b0;
		end else begin
			cfg_reg    <= cfg_next;
			rdata_reg  <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// Millisecond tick and blink phases
	logic [31:0]      tick_cnt_reg;
	logic [31:0]      tick_cnt_next;
	logic             tick_reg;
	logic             tick_next;
	pls_pkg::pls_ms_t fast_cnt_reg;
	pls_pkg::pls_ms_t fast_cnt_next;
	pls_pkg::pls_ms_t slow_cnt_reg;
	pls_pkg::pls_ms_t slow_cnt_next;
	logic             fast_reg;
	logic             fast_next;
	logic             slow_reg;
	logic             slow_next;

	always_comb begin
		tick_cnt_next = tick_cnt_reg + 32'h0000_0001;
		tick_next     = 1'b0;
		if (tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
			tick_cnt_next = 32'h0000_0000;
			tick_next     = 1'b1;
		end
		fast_cnt_next = fast_cnt_reg;
		slow_cnt_next = slow_cnt_reg;
		fast_next     = fast_reg;
		slow_next     = slow_reg;
		if (tick_reg) begin
			fast_cnt_next = fast_cnt_reg + pls_pkg::pls_ms_t'(1);
			slow_cnt_next = slow_cnt_reg + pls_pkg::pls_ms_t'(1);
			if (fast_cnt_reg == pls_pkg::pls_ms_t'(FAST_HALF_MS - 1)) begin
				fast_cnt_next = '0;
				fast_next     = ~fast_reg;
			end
			if (slow_cnt_reg == pls_pkg::pls_ms_t'(SLOW_HALF_MS - 1)) begin
				slow_cnt_next = '0;
				slow_next     = ~slow_reg;
			end
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			tick_cnt_reg <= 32'h0000_0000;
			tick_reg     <= 1'b0;
			fast_cnt_reg <= '0;
			slow_cnt_reg <= '0;
			fast_reg     <= 1'b0;
			slow_reg     <= 1'b0;
		end else begin
			tick_cnt_reg <= tick_cnt_next;
			tick_reg     <= tick_next;
			fast_cnt_reg <= fast_cnt_next;
			slow_cnt_reg <= slow_cnt_next;
			fast_reg     <= fast_next;
			slow_reg     <= slow_next;
		end
	end

	// Hold interval from the hold-time field at bits 3:2
	pls_pkg::pls_ms_t hold_ms;

	always_comb begin
		case (cfg_reg[`PLS_FREQ_HI:`PLS_FREQ_LO])
			2'h0:    hold_ms = pls_pkg::pls_ms_t'(`PLS_HOLD0_MS);
			2'h1:    hold_ms = pls_pkg::pls_ms_t'(`PLS_HOLD1_MS);
			2'h2:    hold_ms = pls_pkg::pls_ms_t'(HOLD2_MS);
			default: hold_ms = pls_pkg::pls_ms_t'(HOLD3_MS);
		endcase
	end

	assign bus.tick       = tick_reg;
	assign bus.blink_fast = fast_reg;
	assign bus.blink_slow = slow_reg;
	assign bus.stretch_en = cfg_reg[`PLS_STRETCH_BIT];
	assign bus.hold_ms    = hold_ms;
	assign bus.speed      = SPEED_100;
	assign bus.tx         = TX_ACTIVE;
	assign bus.rx         = RX_ACTIVE;
	assign bus.col        = COLLISION;
	assign bus.link       = LINK_UP;
	assign bus.duplex     = FULL_DUPLEX;

	// Identical display lanes share one decode table
	logic lit_first;
	logic lit_second;

	pls_lane u_first (
		.clk (REF_CLK),
		.rst (RST),
		.sel (cfg_reg[`PLS_SEL1_HI:`PLS_SEL1_LO]),
		.bus (bus),
		.lit (lit_first)
	);

	pls_lane u_second (
		.clk (REF_CLK),
		.rst (RST),
		.sel (cfg_reg[`PLS_SEL2_HI:`PLS_SEL2_LO]),
		.bus (bus),
		.lit (lit_second)
	);

	assign FIRST_INDICATOR  = lit_first;
	assign SECOND_INDICATOR = lit_second;
	assign REG_RDATA        = rdata_reg;
	assign REG_RD_VALID     = rvalid_reg;

endmodule

// ==== verif/pls_properties.sv ====
`timescale 1ns/1ns
module pls_chk (
	// Clock and reset
	input wire logic               REF_CLK,
	input wire logic               RST,
	// Line status
	input wire logic               SPEED_100,
	input wire logic               TX_ACTIVE,
	input wire logic               RX_ACTIVE,
	input wire logic               LINK_UP,
	input wire logic               FULL_DUPLEX,
	// Register port
	input wire logic [4:0]         REG_ADDR,
	input wire logic               REG_WR_EN,
	input wire logic               REG_RD_EN,
	input wire pls_pkg::pls_word_t REG_WDATA,
	input wire logic [15:0]        REG_RDATA,
	input wire logic               REG_RD_VALID,
	// Indicators
	input wire logic               FIRST_INDICATOR,
	input wire logic               SECOND_INDICATOR
);
	logic [15:0] cfg_reg;
	wire  [3:0]  s1 = cfg_reg[15:12];
	wire  [3:0]  s2 = cfg_reg[11:8];

	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);

	// Shadow of the configuration word
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST)
			cfg_reg <= 16'h0402;
		else if (REG_WR_EN && REG_ADDR == 5'h14)
			cfg_reg <= REG_WDATA & 16'hFF0E;
	end

	sequence cfg_wr;
		REG_WR_EN && REG_ADDR == 5'h14;
	endsequence

	AST_WR_TO_LAMP: assert property (cfg_wr ##0 REG_WDATA[15:12] == 4'h8 |-> ##2 FIRST_INDICATOR)
		else $error("forced-on write not shown");
	AST_SPEED: assert property (!RST && s1 == 4'h0 |=> FIRST_INDICATOR == $past(SPEED_100))
		else $error("speed display wrong");
	AST_LINK: assert property (!RST && s2 == 4'h4 |=> SECOND_INDICATOR == $past(LINK_UP))
		else $error("link display wrong");
	AST_DUP: assert property (!RST && s1 == 4'h5 |=> FIRST_INDICATOR == $past(FULL_DUPLEX))
		else $error("duplex display wrong");
	AST_FORCE: assert property (s1 == 4'h8 && s2 == 4'h9 |=> FIRST_INDICATOR && !SECOND_INDICATOR)
		else $error("forced display wrong");
	AST_UNUSED: assert property (s1 == 4'h6 || s1 == 4'hF |=> !FIRST_INDICATOR)
		else $error("unused code lit");
	AST_EVT: assert property (s1 == 4'h1 && TX_ACTIVE |=> FIRST_INDICATOR)
		else $error("transmit event not shown");
	AST_NOSTR: assert property (s1 == 4'h7 && !cfg_reg[1] && !TX_ACTIVE && !RX_ACTIVE |=> !FIRST_INDICATOR)
		else $error("stretch not disabled");
	AST_RDV: assert property (REG_RD_VALID == $past(REG_RD_EN))
		else $error("read valid timing wrong");
	AST_RDATA: assert property (REG_RD_EN |=> REG_RDATA == ($past(REG_ADDR) == 5'h14 ? $past(cfg_reg) : 16'h0000))
		else $error("read data wrong");
endmodule

bind pls_top pls_chk u_chk (.REF_CLK, .RST, .SPEED_100, .TX_ACTIVE, .RX_ACTIVE, .LINK_UP,
	.FULL_DUPLEX, .REG_ADDR, .REG_WR_EN, .REG_RD_EN, .REG_WDATA, .REG_RDATA, .REG_RD_VALID,
	.FIRST_INDICATOR, .SECOND_INDICATOR);

// ==== verif/pls_leds.sv ====
`timescale 1ns/1ns
module pls_leds (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Lamp drives
	input  wire logic        drive_a,
	input  wire logic        drive_b,
	// Toggles seen on each lamp
	output logic      [15:0] edges_a,
	output logic      [15:0] edges_b
);
	logic prev_a;
	logic prev_b;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{prev_a, prev_b, edges_a, edges_b} <= '0;
		end else begin
			prev_a  <= drive_a;
			prev_b  <= drive_b;
			edges_a <= edges_a + 16'(drive_a ^ prev_a);
			edges_b <= edges_b + 16'(drive_b ^ prev_b);
		end
	end
endmodule

// ==== verif/tb_phy_status_led_select.sv ====
`timescale 1ns/1ns
module tb_phy_status_led_select;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        speed = 1'b1;
	logic        tx = 1'b0;
	logic        rx = 1'b0;
	logic        col = 1'b0;
	logic        link = 1'b0;
	logic        dup = 1'b0;
	logic [4:0]  addr = 5'h00;
	logic        wr_en = 1'b0;
	logic        rd_en = 1'b0;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata;
	logic        rdv;
	logic        first_indicator;
	logic        second_indicator;
	logic [15:0] ea;
	logic [15:0] eb;
	logic [15:0] e1;
	logic [15:0] e2;
	int          fail_count = 0;
	int          num_checks = 0;
	int          hold[4] = '{30, 60, 90, 120};

	always #2 clk = ~clk;

	pls_top #(.TICK_CYCLES(10), .HOLD2_MS(90), .HOLD3_MS(120), .FAST_HALF_MS(2),
		.SLOW_HALF_MS(5)) dut (.REF_CLK(clk), .RST(rst), .SPEED_100(speed),
		.TX_ACTIVE(tx), .RX_ACTIVE(rx), .COLLISION(col), .LINK_UP(link),
		.FULL_DUPLEX(dup), .REG_ADDR(addr), .REG_WR_EN(wr_en), .REG_RD_EN(rd_en),
		.REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RD_VALID(rdv),
		.FIRST_INDICATOR(first_indicator), .SECOND_INDICATOR(second_indicator));
	pls_leds lamps (.clk(clk), .rst(rst), .drive_a(first_indicator), .drive_b(second_indicator),
		.edges_a(ea), .edges_b(eb));

	task conclude;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk_reg(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task chk_led(input logic [1:0] got, input logic [1:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task rd(input logic [4:0] a, input logic [15:0] exp);
		int k;
		@(posedge clk);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		for (k = 0; k < 4 && rdv !== 1'b1; k++)
			@(posedge clk) #1;
		if (k == 4) begin
			fail_count++;
			conclude();
		end else
			chk_reg(rdata, exp);
	endtask
	task mode(input logic [15:0] d, input logic [1:0] exp);
		wr(5'h14, d);
		w(2);
		chk_led({first_indicator, second_indicator}, exp);
	endtask
	task drive(input logic [2:0] v, input logic [1:0] exp);
		@(posedge clk);
		{tx, rx, col} <= v;
		w(2);
		chk_led({first_indicator, second_indicator}, exp);
	endtask
	task pulse(input logic [2:0] v);
		@(posedge clk);
		{tx, rx, col} <= v;
		@(posedge clk);
		{tx, rx, col} <= 3'b000;
	endtask
	task blinks(input logic [1:0] exp);
		e1 = ea;
		e2 = eb;
		w(150);
		chk_led({ea != e1, eb != e2}, exp);
	endtask

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		w(3);
		chk_led({first_indicator, second_indicator}, 2'b10);
		@(posedge clk);
		speed <= 1'b0;
		w(2);
		chk_led({first_indicator, second_indicator}, 2'b00);
		@(posedge clk);
		speed <= 1'b1;
		rd(5'h14, 16'h0402);
		rd(5'h03, 16'h0000);
		wr(5'h03, 16'hFFFF);
		wr(5'h14, 16'hFFFF);
		rd(5'h14, 16'hFF0E);
		$display("test registers done");
		mode(16'h8902, 2'b10);
		mode(16'h9802, 2'b01);
		mode(16'h6F02, 2'b00);
		@(posedge clk);
		link <= 1'b1;
		mode(16'h5402, 2'b01);
		@(posedge clk);
		link <= 1'b0;
		dup  <= 1'b1;
		mode(16'h5402, 2'b10);
		$display("test continuous done");
		mode(16'h7300, 2'b00);
		drive(3'b010, 2'b10);
		drive(3'b100, 2'b10);
		drive(3'b001, 2'b01);
		drive(3'b000, 2'b00);
		mode(16'h2100, 2'b00);
		drive(3'b010, 2'b10);
		drive(3'b100, 2'b01);
		drive(3'b000, 2'b00);
		for (int i = 0; i < 4; i++) begin
			wr(5'h14, 16'h1902 | 16'(i << 2));
			pulse(3'b100);
			w(hold[i] * 10 - 15);
			chk_led({first_indicator, second_indicator}, 2'b10);
			w(40);
			chk_led({first_indicator, second_indicator}, 2'b00);
		end
		wr(5'h14, 16'h1902);
		pulse(3'b100);
		w(200);
		pulse(3'b100);
		w(285);
		chk_led({first_indicator, second_indicator}, 2'b10);
		w(40);
		chk_led({first_indicator, second_indicator}, 2'b00);
		$display("test stretch done");
		@(posedge clk);
		link <= 1'b1;
		mode(16'hDC00, 2'b11);
		pulse(3'b010);
		blinks(2'b11);
		w(400);
		chk_led({first_indicator, second_indicator}, 2'b11);
		mode(16'hE000, 2'b11);
		pulse(3'b001);
		blinks(2'b10);
		$display("test combined done");
		wr(5'h14, 16'hAB02);
		e1 = ea;
		e2 = eb;
		w(200);
		chk_led({ea - e1 > eb - e2, eb != e2}, 2'b11);
		$display("test blink done");
		conclude();
	end
endmodule
